// File: hw/bcpl_pkg.sv
`default_nettype none

package bcpl_pkg;

   // Chip select count field encodings
   localparam logic [1:0] BCPL_CS_COUNT_NONE  = 2'h2;
   localparam logic [1:0] BCPL_CS_COUNT_TWO   = 2'h1;
   localparam logic [1:0] BCPL_CS_COUNT_THREE = 2'h0;
   localparam logic [1:0] BCPL_CS_COUNT_FIVE  = 2'h3;

   // Port 6 pin layout
   localparam int BCPL_NUM_CS       = 5;
   localparam int BCPL_PIN_HOLD     = 5;
   localparam int BCPL_PIN_HOLD_ACK = 6;
   localparam int BCPL_PIN_BUS_REQ  = 7;

   // Bit positions of the captured reset configuration
   localparam int BCPL_CFG_CS_COUNT_LSB = 0;

   // Timing counts
   localparam int BCPL_CLK_MHZ         = 50;
   localparam int BCPL_HOLD_DRIVE_NS   = 20;
   localparam int BCPL_HOLD_DRIVE_CYC  =
      (BCPL_HOLD_DRIVE_NS * BCPL_CLK_MHZ + 999) / 1000 < 1 ? 1 :
      (BCPL_HOLD_DRIVE_NS * BCPL_CLK_MHZ + 999) / 1000;

   // Reset values
   localparam logic [1:0] BCPL_CS_COUNT_RESET = BCPL_CS_COUNT_NONE;

endpackage : bcpl_pkg

`default_nettype wire

// File: hw/bcpl_cs_count.sv
`timescale 1ns/10ps
`default_nettype none

// Decodes the chip select count field into a per-pin enable mask
module bcpl_cs_count
   import bcpl_pkg::*;
(
   input  wire logic [1:0]             chip_select_count_field,
   output logic      [BCPL_NUM_CS-1:0] cs_enable
);

   always_comb begin
      if (chip_select_count_field == BCPL_CS_COUNT_TWO) begin
         cs_enable = 5'h03;
      end else if (chip_select_count_field == BCPL_CS_COUNT_THREE) begin
         cs_enable = 5'h07;
      end else if (chip_select_count_field == BCPL_CS_COUNT_FIVE) begin
         cs_enable = 5'h1f;
      end else begin
         cs_enable = 5'h00;
      end
   end

endmodule : bcpl_cs_count

`default_nettype wire

// File: hw/bcpl_top.sv
// Operation
// (R1) Capture chip select count at reset: 10 none, 01 two, 00 three, 11 five.
// (R2) Captured count field readable as read-only reset configuration.
// (R3) Three upper pins carry hold request, hold acknowledge, bus request.
// (R4) Chip select weak pull-ups always on during reset.
// (R5) In hold, pull-up on for chip selects in push/pull mode.
// (R6) Open drain chip select: no pull-up in hold; system provides one.
// (R7) Entering hold drives chip selects high one phase, then releases them.
// (R8) After reset configured chip selects take their function automatically.
// (R9) First chip select is push/pull directly after reset.
// (R10) Arbitration pins work only when arbitration enable bit set.
// (R11) Arbitration enabled: drive acknowledge and request, hold request input only.
// (R12) Address latch strobe pulses for every external bus cycle.
// (R13) With a bus active bit set, extended peripheral accesses pulse it too.
// (R14) Strobe quiet for internal accesses, and peripherals with no bus active.
// (R15) Read and write strobes high in reset, hold and peripheral accesses.
// (R16) Write strobe is general or low-byte paired with high-byte strobe.
// (R17) Ready ends ready-controlled cycles, synchronous or asynchronous evaluation.
// (R18) Ready ignored during programmed waitstates of a ready window.
// (R19) After reset fetch internal when access select high, external when low.
// (R20) Nonmaskable input sampled each cycle; transition raises trap, validates power-down.
// (R21) Reset output low from any reset until end-of-init executes.
// (R22) Oscillator watchdog active while its pin high; low bypasses it.
// (R23) Enabled chip select low while access hits its window, else high.
`timescale 1ns/10ps
`default_nettype none

module bcpl_top
   import bcpl_pkg::*;
#(
   parameter int NUM_CS = BCPL_NUM_CS
)
(
   input  wire logic              clk,
   input  wire logic              reset,
   // Reset configuration from the data port
   input  wire logic [1:0]        cfg_cs_count_in,
   input  wire logic              external_access_sel_n,
   // Software controls
   input  wire logic [NUM_CS-1:0] open_drain_ctrl,
   input  wire logic              arbitration_enable,
   input  wire logic [NUM_CS-1:0] bus_active_bit,
   input  wire logic              wr_split_mode,
   input  wire logic              end_init_instr,
   input  wire logic              soft_reset_instr,
   input  wire logic              watchdog_overflow,
   input  wire logic              power_down_instr,
   // Bus controller access requests
   input  wire logic              acc_start,
   input  wire logic              acc_external,
   input  wire logic              acc_xper,
   input  wire logic              acc_read,
   input  wire logic              acc_write,
   input  wire logic              acc_high_byte,
   input  wire logic              acc_low_byte,
   input  wire logic [NUM_CS-1:0] acc_window_hit,
   input  wire logic              acc_ready_ctrl,
   input  wire logic              acc_ready_async,
   input  wire logic              acc_in_waitstate,
   input  wire logic              acc_end,
   input  wire logic              hold_mode,
   input  wire logic              bus_request_int,
   // Pins
   input  wire logic              hold_req_in,
   input  wire logic              ready_in,
   input  wire logic              nmi_in,
   input  wire logic              osc_watchdog_en,
   // Chip select pins (four-signal form)
   output logic      [NUM_CS-1:0] cs_out_n,
   output logic      [NUM_CS-1:0] cs_oe,
   output logic      [NUM_CS-1:0] cs_pullup_en,
   output logic      [NUM_CS-1:0] cs_func_sel,
   // Arbitration pins
   output logic                   hold_ack_out,
   output logic                   hold_ack_oe,
   output logic                   bus_request_out,
   output logic                   bus_request_oe,
   output logic                   hold_pin_oe,
   output logic                   hold_req_sync,
   // Strobes
   output logic                   ale_out,
   output logic                   read_strobe_n,
   output logic                   write_strobe_n,
   output logic                   write_high_strobe_n,
   output logic                   strobe_pullup_en,
   // Status
   output logic [1:0]             reset_config_latch,
   output logic                   boot_internal,
   output logic                   ready_done,
   output logic                   nmi_trap,
   output logic                   power_down_ok,
   output logic                   reset_out_n,
   output logic                   osc_watchdog_active
);

   ////////////////////////////////////////////////////////////////////////
   // Reset configuration capture

   logic              cfg_pending_q;
   logic [1:0]        cs_count_q;
   logic [NUM_CS-1:0] cs_en;

   // Async reset loads constants; the pins are caught on the first edge after release
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_pending_q <= 1'b1;
         cs_count_q    <= BCPL_CS_COUNT_RESET;
         boot_internal <= 1'b1;
      end else if (cfg_pending_q) begin
         cfg_pending_q <= 1'b0;
         cs_count_q    <= cfg_cs_count_in;           // see (R1)
         boot_internal <= external_access_sel_n;     // see (R19)
      end
   end

   assign reset_config_latch = cs_count_q;           // see (R2)

   bcpl_cs_count u_cs_count (
      .chip_select_count_field (cs_count_q),
      .cs_enable               (cs_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // Chip select pins

   logic hold_q;
   logic hold_entry;
   logic [$clog2(BCPL_HOLD_DRIVE_CYC+1)-1:0] drive_cnt_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= hold_mode;
      end
   end

   assign hold_entry = hold_mode && !hold_q;

   // Counts the forced-high phase after hold entry
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drive_cnt_q <= '0;
      end else if (hold_entry) begin
         drive_cnt_q <= ($clog2(BCPL_HOLD_DRIVE_CYC+1))'(BCPL_HOLD_DRIVE_CYC);  // see (R7)
      end else if (drive_cnt_q != '0) begin
         drive_cnt_q <= drive_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cs_out_n     <= '1;
         cs_oe        <= '0;
         cs_pullup_en <= '1;                         // see (R4)
         cs_func_sel  <= '0;
      end else begin
         // Function select follows the captured count with no port latch setup
         cs_func_sel <= cs_en;                       // see (R8)
         for (int i = 0; i < NUM_CS; i++) begin
            if (cfg_pending_q) begin
               cs_out_n[i]     <= 1'b1;
               cs_oe[i]        <= 1'b0;
               cs_pullup_en[i] <= 1'b1;              // see (R4)
            end else if (hold_mode) begin
               cs_out_n[i]     <= 1'b1;
               // Brief active high avoids a slow pull-up rise during handover
               cs_oe[i]        <= cs_en[i] && (hold_entry || drive_cnt_q > 1);  // see (R7)
               cs_pullup_en[i] <= cs_en[i] && !open_drain_ctrl[i];  // see (R5) see (R6)
            end else begin
               cs_out_n[i]     <= !(cs_en[i] && acc_external && acc_window_hit[i]);  // see (R23)
               // Open drain drives only while selecting; control bits reset to push/pull
               cs_oe[i]        <= cs_en[i] && (!open_drain_ctrl[i] ||
                                  (acc_external && acc_window_hit[i]));  // see (R9)
               cs_pullup_en[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus arbitration pins

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_ack_out    <= 1'b1;
         hold_ack_oe     <= 1'b0;
         bus_request_out <= 1'b1;
         bus_request_oe  <= 1'b0;
         hold_pin_oe     <= 1'b0;
         hold_req_sync   <= 1'b0;
      end else begin
         hold_ack_oe     <= arbitration_enable;      // see (R11)
         bus_request_oe  <= arbitration_enable;      // see (R11)
         hold_pin_oe     <= 1'b0;                    // see (R11)
         hold_ack_out    <= !(arbitration_enable && hold_mode);      // see (R3) see (R10)
         bus_request_out <= !(arbitration_enable && bus_request_int);// see (R3) see (R10)
         hold_req_sync   <= arbitration_enable && !hold_req_in;      // see (R10)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address latch and command strobes

   logic bus_on;
   logic ale_d;
   logic strobe_block;

   assign bus_on = |bus_active_bit;
   // Internal memory and registers never reach here as acc_external
   assign ale_d  = acc_start && (acc_external || (acc_xper && bus_on));  // see (R12) see (R13) see (R14)
   assign strobe_block = cfg_pending_q || hold_mode || acc_xper || !acc_external;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ale_out             <= 1'b0;
         read_strobe_n       <= 1'b1;
         write_strobe_n      <= 1'b1;
         write_high_strobe_n <= 1'b1;
         strobe_pullup_en    <= 1'b1;
      end else begin
         ale_out          <= ale_d;
         strobe_pullup_en <= cfg_pending_q || hold_mode;             // see (R15)
         if (strobe_block) begin
            read_strobe_n       <= 1'b1;                             // see (R15)
            write_strobe_n      <= 1'b1;
            write_high_strobe_n <= 1'b1;
         end else begin
            read_strobe_n <= !acc_read;
            if (wr_split_mode) begin
               write_strobe_n      <= !(acc_write && acc_low_byte);  // see (R16)
               write_high_strobe_n <= !(acc_write && acc_high_byte);
            end else begin
               write_strobe_n      <= !acc_write;                    // see (R16)
               write_high_strobe_n <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready evaluation

   logic ready_s1_q;
   logic ready_s2_q;
   logic ready_eval;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ready_s1_q <= 1'b1;
         ready_s2_q <= 1'b1;
      end else begin
         ready_s1_q <= ready_in;
         ready_s2_q <= ready_s1_q;
      end
   end

   // Async mode pays two cycles of latency for metastability safety
   assign ready_eval = acc_ready_async ? !ready_s2_q : !ready_in;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ready_done <= 1'b0;
      end else begin
         ready_done <= acc_external && acc_ready_ctrl && !acc_in_waitstate
                       && ready_eval;                // see (R17) see (R18)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Nonmaskable interrupt, reset output, oscillator watchdog

   logic nmi_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         nmi_q         <= 1'b1;
         nmi_trap      <= 1'b0;
         power_down_ok <= 1'b0;
      end else begin
         nmi_q         <= nmi_in;                    // see (R20)
         nmi_trap      <= nmi_q && !nmi_in;          // see (R20)
         power_down_ok <= power_down_instr && !nmi_in;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reset_out_n <= 1'b0;                        // see (R21)
      end else if (soft_reset_instr || watchdog_overflow) begin
         reset_out_n <= 1'b0;                        // see (R21)
      end else if (end_init_instr) begin
         reset_out_n <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         osc_watchdog_active <= 1'b1;
      end else begin
         osc_watchdog_active <= osc_watchdog_en;     // see (R22)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_cs_reset_pullup: assert property (@(posedge clk) disable iff (reset)
      cfg_pending_q |=> cs_pullup_en == '1)          // see (R4)
      else $error("chip select pull-ups off during reset");

   a_cs_hold_pullup: assert property (@(posedge clk) disable iff (reset)
      (hold_mode && !cfg_pending_q) |=> cs_pullup_en == $past(cs_en & ~open_drain_ctrl))  // see (R5)
      else $error("hold pull-up mismatch");

   a_cs_hold_drive: assert property (@(posedge clk) disable iff (reset)
      (hold_entry && !cfg_pending_q && cs_en != '0) |=> (cs_oe != '0) ##1 (!hold_q || cs_oe == '0))  // see (R7)
      else $error("hold entry drive phase wrong");

   a_arb_gate: assert property (@(posedge clk) disable iff (reset)
      !arbitration_enable |=> hold_ack_out && bus_request_out && !hold_ack_oe)  // see (R10)
      else $error("arbitration pins active while disabled");

   a_ale_quiet: assert property (@(posedge clk) disable iff (reset)
      (acc_start && acc_xper && !acc_external && !bus_on) |=> !ale_out)  // see (R14)
      else $error("address strobe in single chip peripheral access");

   a_strobe_hold: assert property (@(posedge clk) disable iff (reset)
      hold_mode |=> read_strobe_n && write_strobe_n && write_high_strobe_n)  // see (R15)
      else $error("command strobe active in hold");

   a_ready_wait: assert property (@(posedge clk) disable iff (reset)
      acc_in_waitstate |=> !ready_done)              // see (R18)
      else $error("ready taken during waitstate");

   a_nmi_edge: assert property (@(posedge clk) disable iff (reset)
      ($fell(nmi_in)) |=> nmi_trap)                  // see (R20)
      else $error("nmi transition missed");

   a_rst_out_hold: assert property (@(posedge clk) disable iff (reset)
      (!reset_out_n && !end_init_instr) |=> !reset_out_n)  // see (R21)
      else $error("reset output released early");

   a_cfg_latch: assert property (@(posedge clk) disable iff (reset)
      cfg_pending_q |=> reset_config_latch == $past(cfg_cs_count_in) ##1 $stable(reset_config_latch))  // see (R1)
      else $error("count field not captured");

endmodule : bcpl_top

`default_nettype wire

// File: test/bcpl_far_side.sv
`timescale 1ns/10ps
`default_nettype none

// External memory and bus wiring seen from the pins
module bcpl_far_side (
   input  wire logic       clk,
   input  wire logic [3:0] ready_wait,
   input  wire logic       read_strobe_n,
   input  wire logic       write_strobe_n,
   input  wire logic [4:0] cs_out_n,
   input  wire logic [4:0] cs_oe,
   output logic            ready_in,
   output logic      [4:0] cs_level
);
   logic [3:0] wait_q = 4'h0;
   logic       rdy_q  = 1'b1;

   ////////////////////////////////////////////////////////////
   // Ready answers after ready_wait strobe cycles; idle line rests at its pull-up
   always @(posedge clk) begin
      if (read_strobe_n && write_strobe_n) begin
         wait_q <= 4'h0;
         rdy_q  <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
         rdy_q  <= !(wait_q >= ready_wait);
      end
   end
   assign ready_in = rdy_q;

   ////////////////////////////////////////////////////////////
   // Board pull-ups hold undriven chip selects high
   assign cs_level = (cs_oe & cs_out_n) | ~cs_oe;
endmodule : bcpl_far_side

`default_nettype wire

// File: test/bcpl_top_test.sv
`timescale 1ns/10ps
`default_nettype none

module bcpl_top_test;
   import bcpl_pkg::*;
   logic       clk = 1'b0, reset = 1'b1, external_access_sel_n = 1'b1;
   logic [1:0] cfg_cs_count_in = 2'h0;
   logic [4:0] open_drain_ctrl = 5'h00, bus_active_bit = 5'h00, acc_window_hit = 5'h00;
   logic       arbitration_enable = 1'b0, wr_split_mode = 1'b0, acc_start = 1'b0, acc_external = 1'b0;
   logic       acc_xper = 1'b0, acc_read = 1'b0, acc_write = 1'b0, acc_high_byte = 1'b0, acc_low_byte = 1'b0;
   logic       acc_ready_ctrl = 1'b0, acc_ready_async = 1'b0, acc_in_waitstate = 1'b0, acc_end = 1'b0;
   logic       hold_mode = 1'b0, bus_request_int = 1'b0, hold_req_in = 1'b1, nmi_in = 1'b1;
   logic       osc_watchdog_en = 1'b1, ready_in;
   logic [3:0] instr_q = 4'h0, ready_wait = 4'h0, pulse_v;
   wire logic  end_init_instr, soft_reset_instr, watchdog_overflow, power_down_instr;
   logic [4:0] cs_out_n, cs_oe, cs_pullup_en, cs_func_sel, cs_level;
   logic       hold_ack_out, hold_ack_oe, bus_request_out, bus_request_oe, hold_pin_oe, hold_req_sync;
   logic       ale_out, read_strobe_n, write_strobe_n, write_high_strobe_n, strobe_pullup_en;
   logic [1:0] reset_config_latch;
   logic       boot_internal, ready_done, nmi_trap, power_down_ok, reset_out_n, osc_watchdog_active;
   int         fails = 0, check_count = 0;

   assign {power_down_instr, watchdog_overflow, soft_reset_instr, end_init_instr} = instr_q;
   assign pulse_v = {ready_done, nmi_trap, power_down_ok, hold_req_sync};
   always #10 clk = ~clk;

   bcpl_top u_bcpl_top (.clk, .reset, .cfg_cs_count_in, .external_access_sel_n, .open_drain_ctrl,
      .arbitration_enable, .bus_active_bit, .wr_split_mode, .end_init_instr, .soft_reset_instr,
      .watchdog_overflow, .power_down_instr, .acc_start, .acc_external, .acc_xper, .acc_read,
      .acc_write, .acc_high_byte, .acc_low_byte, .acc_window_hit, .acc_ready_ctrl, .acc_ready_async,
      .acc_in_waitstate, .acc_end, .hold_mode, .bus_request_int, .hold_req_in, .ready_in, .nmi_in,
      .osc_watchdog_en, .cs_out_n, .cs_oe, .cs_pullup_en, .cs_func_sel, .hold_ack_out, .hold_ack_oe,
      .bus_request_out, .bus_request_oe, .hold_pin_oe, .hold_req_sync, .ale_out, .read_strobe_n,
      .write_strobe_n, .write_high_strobe_n, .strobe_pullup_en, .reset_config_latch, .boot_internal,
      .ready_done, .nmi_trap, .power_down_ok, .reset_out_n, .osc_watchdog_active);
   bcpl_far_side u_bcpl_far_side (.clk, .ready_wait, .read_strobe_n, .write_strobe_n, .cs_out_n,
      .cs_oe, .ready_in, .cs_level);

   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", n, e, g);
      end
   endtask : chk
   task automatic chkv(input string n, input logic [4:0] e, input logic [4:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chkv
   // Looks at the current cycle first, so a pulse on the launching edge is not missed
   task automatic seek(input int idx, input int lim, output logic seen);
      seen = pulse_v[idx];
      repeat (lim) begin
         @(posedge clk);
         #1;
         seen = seen | pulse_v[idx];
      end
   endtask : seek
   task automatic strobe(input int k);
      @(posedge clk);
      instr_q <= 4'h1 << k;
      @(posedge clk);
      instr_q <= 4'h0;
      #1;
   endtask : strobe
   task automatic access(input logic ext, xp, rd, hi, lo, input logic [4:0] hit);
      @(posedge clk);
      {acc_start, acc_external, acc_xper, acc_read, acc_write} <= {2'b11, xp, rd, !rd} & {1'b1, ext, 3'h7};
      {acc_high_byte, acc_low_byte, acc_window_hit} <= {hi, lo, hit};
      @(posedge clk);
      acc_start <= 1'b0;
      #1;
   endtask : access
   task automatic idle();
      @(posedge clk);
      {acc_external, acc_xper, acc_read, acc_write, acc_high_byte, acc_low_byte} <= 6'h00;
      {acc_window_hit, acc_ready_ctrl, acc_ready_async, acc_in_waitstate} <= 8'h00;
      repeat (2) @(posedge clk);
      #1;
   endtask : idle
   task automatic do_reset(input logic [1:0] code, input logic boot_sel);
      @(posedge clk);
      {reset, cfg_cs_count_in, external_access_sel_n} <= {1'b1, code, boot_sel};
      repeat (5) @(posedge clk);
      #1;
      chkv("reset pullups", 5'h1f, cs_pullup_en);
      chk("reset read strobe", 1'b1, read_strobe_n & write_strobe_n);
      @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chkv("count field", {3'h0, code}, {3'h0, reset_config_latch});
      chk("boot internal", boot_sel, boot_internal);
      chk("reset out", 1'b0, reset_out_n);
   endtask : do_reset

   ////////////////////////////////////////////////////////////
   task automatic t_count();
      logic [1:0] codes [4] = '{BCPL_CS_COUNT_NONE, BCPL_CS_COUNT_TWO, BCPL_CS_COUNT_THREE, BCPL_CS_COUNT_FIVE};
      logic [4:0] masks [4] = '{5'h00, 5'h03, 5'h07, 5'h1f};
      for (int i = 0; i < 4; i++) begin
         do_reset(codes[i], i[0]);
         chkv("cs function", masks[i], cs_func_sel);
      end
   endtask : t_count
   task automatic t_access();
      access(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 5'h01);
      chk("ale external", 1'b1, ale_out);
      chk("read strobe", 1'b0, read_strobe_n);
      chkv("cs select", 5'h1e, cs_out_n);
      chk("cs0 driven", 1'b1, cs_oe[0]);
      idle();
      chk("ale ended", 1'b0, ale_out);
      chkv("cs idle", 5'h1f, cs_out_n);
      access(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 5'h00);
      chk("ale periph no bus", 1'b0, ale_out | !read_strobe_n);
      idle();
      @(posedge clk);
      bus_active_bit <= 5'h01;
      access(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h00);
      chk("ale periph bus", 1'b1, ale_out & write_strobe_n);
      idle();
      access(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h00);
      chk("ale internal", 1'b0, ale_out);
      idle();
      access(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00);
      chk("general write", 1'b0, write_strobe_n | !write_high_strobe_n);
      idle();
      @(posedge clk);
      wr_split_mode <= 1'b1;
      access(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00);
      chkv("split write", 5'h02, {3'h0, write_strobe_n, write_high_strobe_n});
      idle();
   endtask : t_access
   task automatic t_hold();
      @(posedge clk);
      open_drain_ctrl <= 5'h05;
      @(posedge clk);
      hold_mode <= 1'b1;
      @(posedge clk);
      #1;
      chkv("hold entry drive", 5'h1f, cs_oe & cs_out_n);
      @(posedge clk);
      #1;
      chkv("hold release", 5'h00, cs_oe);
      chkv("hold pullups", 5'h1a, cs_pullup_en);
      chkv("hold cs wire", 5'h1f, cs_level);
      chk("hold strobes", 1'b1, read_strobe_n & write_strobe_n & strobe_pullup_en);
      @(posedge clk);
      hold_mode <= 1'b0;
      open_drain_ctrl <= 5'h00;
   endtask : t_hold
   task automatic t_arb();
      logic seen;
      @(posedge clk);
      {bus_request_int, hold_req_in, hold_mode} <= 3'b101;
      seek(0, 4, seen);
      chk("arb off request", 1'b0, seen | !bus_request_out | !hold_ack_out | hold_ack_oe);
      @(posedge clk);
      arbitration_enable <= 1'b1;
      seek(0, 4, seen);
      chk("arb hold request", 1'b1, seen & !bus_request_out & !hold_ack_out);
      chkv("arb drivers", 5'h06, {2'h0, hold_ack_oe, bus_request_oe, hold_pin_oe});
      @(posedge clk);
      {arbitration_enable, bus_request_int, hold_req_in, hold_mode} <= 4'b0010;
   endtask : t_arb
   task automatic t_ready(input logic [3:0] w, input logic am, ws, exp);
      logic seen;
      @(posedge clk);
      {ready_wait, acc_ready_ctrl, acc_ready_async, acc_in_waitstate} <= {w, 1'b1, am, ws};
      access(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 5'h01);
      seek(3, 12, seen);
      chk("ready end", exp, seen);
      idle();
   endtask : t_ready
   task automatic t_misc();
      logic seen;
      @(posedge clk);
      nmi_in <= 1'b0;
      seek(2, 4, seen);
      chk("nmi trap", 1'b1, seen);
      strobe(3);
      seek(1, 3, seen);
      chk("power down valid", 1'b1, seen);
      @(posedge clk);
      nmi_in <= 1'b1;
      strobe(3);
      seek(1, 3, seen);
      chk("power down refused", 1'b0, seen);
      for (int k = 0; k < 4; k++) begin
         strobe(k == 3 ? 0 : k);
         @(posedge clk);
         #1;
         chk("reset out", (k == 0 || k == 3), reset_out_n);
      end
      chk("osc watchdog on", 1'b1, osc_watchdog_active);
      @(posedge clk);
      osc_watchdog_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("osc watchdog off", 1'b0, osc_watchdog_active);
   endtask : t_misc

   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   initial begin
      t_count();
      t_access();
      t_hold();
      t_arb();
      t_ready(4'h0, 1'b0, 1'b0, 1'b1);
      t_ready(4'h4, 1'b1, 1'b0, 1'b1);
      t_ready(4'h0, 1'b0, 1'b1, 1'b0);
      t_misc();
      wrap_up();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #100000;
      fails++;
      wrap_up();
   end
endmodule : bcpl_top_test

`default_nettype wire
